/* File: core/psp_playback.sv */
// Sequence playback controller: tasks, two RAM sequences, chaining, events and pin routing.
// Assumes the wave counter pulses periodDone at each period end and takes dutyValue on dutyLoad.
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

// Overview of operation
// RQ1 - Loop end keeps last value, ignores hold, tail
// RQ2 - Chain: seq0, tail0, seq1, tail1, repeat
// RQ3 - Playback begins with the launched sequence
// RQ4 - Chained playback ends with sequence 1
// RQ5 - Fetches stay within base and entry total
// RQ6 - Hold setting adds periods between loads
// RQ7 - Repeat total counts sequence 1 passes
// RQ8 - Tail delay one inserts one period
// RQ9 - Tail delay zero switches immediately
// RQ10 - Repeat one: both finish events, then stop
// RQ11 - Manual step loads on next period
// RQ12 - Software gives used sequences nonzero totals
// RQ13 - Late fetch repeats previous compare value
// RQ14 - Channels route to selected pin or none
// RQ15 - Pin selects act while enabled; lost powered-off
// RQ16 - Software presets used pins as GPIO low outputs
// RQ17 - Halt, disable or sleep returns pins idle
// RQ18 - Software assigns each pin one driver only
// RQ19 - Halt at period end, raise halted event
// RQ20 - Base and total sampled at sequence start; the code samples a chained sequence's when the other's last entry is applied
// RQ21 - Hold and tail resampled on each load
// RQ22 - Finish event when last entry applied
// RQ23 - Sequential 16-bit reads, restart at launch
module psp_playback #(
  parameter int ADDR_W = 32,
  parameter int TOTAL_W = 15,
  parameter int HOLD_W = 24,
  parameter int LOOP_W = 16,
  parameter int NUM_PINS = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [31:0] regRdata,
  input wire logic periodDone,
  input wire logic [3:0] chanWave,
  output logic waveRun,
  output logic [15:0] dutyValue,
  output logic dutyLoad,
  output logic memRdReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic memRdAck,
  input wire logic [15:0] memRdData,
  input wire logic powerOff,
  output logic [psp_pkg::EV_COUNT-1:0] eventPulse,
  output logic [NUM_PINS-1:0] pinOut,
  output logic [NUM_PINS-1:0] pinOe
);

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  logic enable;
  logic manualStepMode;
  logic [LOOP_W-1:0] chainRepeatTotal;
  logic [ADDR_W-1:0] seqBaseAddress [2];
  logic [TOTAL_W-1:0] seqEntryTotal [2];
  logic [HOLD_W-1:0] seqHold [2];
  logic [HOLD_W-1:0] seqTailDelay [2];
  logic [127:0] pinSelect;
  logic [psp_pkg::EV_COUNT-1:0] evSticky;

  wire wrSeq0 = regWr && regAddr[7:4] == psp_pkg::OFF_SEQ0[7:4];
  wire wrSeq1 = regWr && regAddr[7:4] == psp_pkg::OFF_SEQ1[7:4];
  wire wrPsel = regWr && regAddr[7:4] == psp_pkg::OFF_PSEL[7:4];
  wire wrTask = regWr && regAddr == psp_pkg::OFF_TASKS;
  wire taskStop = wrTask && regWdata[psp_pkg::TASK_STOP];
  wire [1:0] taskLaunch = {2{wrTask}} & regWdata[psp_pkg::TASK_LAUNCH1:psp_pkg::TASK_LAUNCH0];
  wire taskStep = wrTask && regWdata[psp_pkg::TASK_STEP];
  wire active = enable && !powerOff;

  // ----------------------------------------------------------------
  // Playback state
  // ----------------------------------------------------------------
  psp_pkg::psp_state_e state;
  logic cur;
  logic genOn;
  logic stopPending;
  logic stepPending;
  logic lastApplied;
  logic [ADDR_W-1:0] actBase;
  logic [TOTAL_W-1:0] actTotal;
  logic [ADDR_W-1:0] nextBase;
  logic [TOTAL_W-1:0] nextTotal;
  logic [TOTAL_W-1:0] idx;
  logic [HOLD_W-1:0] holdLeft;
  logic [HOLD_W-1:0] tailSet;
  logic [HOLD_W-1:0] tailLeft;
  logic [LOOP_W-1:0] loopsLeft;
  logic fetchValid;
  logic [15:0] fetchData;

  wire launchAny = |taskLaunch;
  wire launchSel = taskLaunch[1] && !taskLaunch[0];
  wire chainOn = chainRepeatTotal != '0;
  wire inPlay = state == psp_pkg::PSP_PLAY;
  wire loadDue = inPlay && periodDone && (manualStepMode ? stepPending : holdLeft == '0);
  wire applyLoad = state == psp_pkg::PSP_LOAD && (!genOn || periodDone);
  wire applyStep = loadDue && !lastApplied;
  wire switchSeq = (loadDue && lastApplied && tailSet == '0) ||
                   (state == psp_pkg::PSP_TAIL && periodDone && tailLeft == '0);
  wire applyAny = applyLoad || applyStep || switchSeq;
  wire haltNow = stopPending && (periodDone || !genOn) && !launchAny;
  wire applyNow = applyAny && fetchValid && !haltNow && !launchAny;
  wire applySeq = switchSeq ? !cur : cur;
  wire [ADDR_W-1:0] applyBase = switchSeq ? nextBase : actBase;
  wire [TOTAL_W-1:0] applyTotal = switchSeq ? nextTotal : actTotal;
  wire [TOTAL_W-1:0] applyIdx = applyStep ? idx + 1'b1 : '0;
  wire isLast = applyIdx == applyTotal - 1'b1;
  wire chainGoes = chainOn && !(applySeq && loopsLeft == LOOP_W'(1));
  wire [TOTAL_W-1:0] followIdx = applyIdx + 1'b1;
  wire [ADDR_W-1:0] entryAddr = applyBase + (ADDR_W'(followIdx) << psp_pkg::ENTRY_BYTES_LOG2);
  wire fetchGo = launchAny || (applyNow && (!isLast || chainGoes));
  wire [ADDR_W-1:0] fetchAddr = launchAny ? seqBaseAddress[launchSel] :
                                (!isLast ? entryAddr : seqBaseAddress[!applySeq]);
  wire dropAll = !active;

  psp_fetch #(.ADDR_W(ADDR_W)) u_fetch (
    .clk(clk),
    .sys_rst(sys_rst),
    .fetchGo(fetchGo), // RQ23
    .fetchAddr(fetchAddr),
    .fetchTake(applyNow),
    .fetchValid(fetchValid),
    .fetchData(fetchData),
    .memRdReq(memRdReq),
    .memAddr(memAddr),
    .memRdAck(memRdAck),
    .memRdData(memRdData)
  );

  psp_pinmap #(.NUM_PINS(NUM_PINS), .NUM_CH(4)) u_pins (
    .clk(clk),
    .sys_rst(sys_rst),
    .driveOn(genOn && active), // RQ15
    .chanWave(chanWave),
    .pinSelect(pinSelect),
    .pinOut(pinOut),
    .pinOe(pinOe)
  );

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  // Pin selects are held only while powered; a power-off wipes them to detached.
  always_ff @(posedge clk)
  begin
    if (sys_rst || powerOff)
    begin
      pinSelect <= {4{psp_pkg::PSEL_RESET}}; // RQ15
    end
    else if (wrPsel)
    begin
      pinSelect[regAddr[3:2]*32 +: 32] <= regWdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      enable <= 1'b0;
      manualStepMode <= 1'b0;
      chainRepeatTotal <= '0;
      seqBaseAddress <= '{default: '0};
      seqEntryTotal <= '{default: '0};
      seqHold <= '{default: '0};
      seqTailDelay <= '{default: '0};
    end
    else
    begin
      if (regWr && regAddr == psp_pkg::OFF_ENABLE)
        enable <= regWdata[0];
      if (regWr && regAddr == psp_pkg::OFF_DECODE)
        manualStepMode <= regWdata[0];
      if (regWr && regAddr == psp_pkg::OFF_CHAIN)
        chainRepeatTotal <= regWdata[LOOP_W-1:0];
      if (wrSeq0 || wrSeq1)
      begin
        case (regAddr[3:0])
          psp_pkg::SUB_BASE[3:0]: seqBaseAddress[wrSeq1] <= regWdata[ADDR_W-1:0];
          psp_pkg::SUB_TOTAL[3:0]: seqEntryTotal[wrSeq1] <= regWdata[TOTAL_W-1:0];
          psp_pkg::SUB_HOLD[3:0]: seqHold[wrSeq1] <= regWdata[HOLD_W-1:0];
          psp_pkg::SUB_TAIL[3:0]: seqTailDelay[wrSeq1] <= regWdata[HOLD_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Events: pulses and sticky copies, a new event beats a clear
  // ----------------------------------------------------------------
  logic [psp_pkg::EV_COUNT-1:0] evNow;
  always_comb
  begin
    evNow = '0;
    evNow[psp_pkg::EV_STOPPED] = haltNow && state != psp_pkg::PSP_IDLE; // RQ19
    evNow[psp_pkg::EV_BEGUN0] = applyNow && applyIdx == '0 && !applySeq;
    evNow[psp_pkg::EV_BEGUN1] = applyNow && applyIdx == '0 && applySeq;
    evNow[psp_pkg::EV_FINISH0] = applyNow && isLast && !applySeq; // RQ22
    evNow[psp_pkg::EV_FINISH1] = applyNow && isLast && applySeq; // RQ22
    evNow[psp_pkg::EV_PERIOD] = periodDone && genOn;
    evNow[psp_pkg::EV_LOOPS] = applyNow && isLast && applySeq && chainOn && !chainGoes; // RQ10
  end

  wire [psp_pkg::EV_COUNT-1:0] evClear = (regWr && regAddr == psp_pkg::OFF_EVENTS) ?
                                          regWdata[psp_pkg::EV_COUNT-1:0] : '0;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      eventPulse <= '0;
      evSticky <= '0;
    end
    else
    begin
      eventPulse <= evNow;
      evSticky <= (evSticky & ~evClear) | evNow;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (sys_rst || dropAll)
    begin
      state <= psp_pkg::PSP_IDLE;
      genOn <= 1'b0; // RQ17
      cur <= 1'b0;
      stopPending <= 1'b0;
      stepPending <= 1'b0;
      lastApplied <= 1'b0;
      actBase <= '0;
      actTotal <= '0;
      nextBase <= '0;
      nextTotal <= '0;
      idx <= '0;
      holdLeft <= '0;
      tailSet <= '0;
      tailLeft <= '0;
      loopsLeft <= '0;
      dutyValue <= '0;
      dutyLoad <= 1'b0;
    end
    else
    begin
      dutyLoad <= applyNow;
      if (taskStop)
        stopPending <= 1'b1;
      else if (launchAny || haltNow)
        stopPending <= 1'b0;
      if (taskStep && genOn && manualStepMode)
        stepPending <= 1'b1; // RQ11
      else if (loadDue)
        stepPending <= 1'b0;
      if (launchAny)
      begin
        state <= psp_pkg::PSP_LOAD;
        cur <= launchSel; // RQ3
        actBase <= seqBaseAddress[launchSel]; // RQ20
        actTotal <= seqEntryTotal[launchSel]; // RQ20
        loopsLeft <= chainRepeatTotal;
        lastApplied <= 1'b0;
      end
      else if (haltNow)
      begin
        state <= psp_pkg::PSP_IDLE; // RQ19
        genOn <= 1'b0;
      end
      else
      begin
        if (inPlay && periodDone && !manualStepMode && holdLeft != '0)
          holdLeft <= holdLeft - 1'b1; // RQ6
        if (state == psp_pkg::PSP_TAIL && periodDone && tailLeft != '0)
          tailLeft <= tailLeft - 1'b1; // RQ8
        if (loadDue && lastApplied && tailSet != '0)
        begin
          state <= psp_pkg::PSP_TAIL; // RQ2
          tailLeft <= tailSet - 1'b1;
        end
        if (switchSeq)
        begin
          cur <= !cur; // RQ9
          actBase <= nextBase; // RQ20
          actTotal <= nextTotal;
          lastApplied <= 1'b0;
          state <= psp_pkg::PSP_LOAD;
        end
        // Without a fresh entry the compare value simply stays, never a half update. RQ13
        if (applyNow)
        begin
          dutyValue <= fetchData;
          genOn <= 1'b1;
          idx <= applyIdx; // RQ5
          holdLeft <= seqHold[applySeq]; // RQ21
          tailSet <= seqTailDelay[applySeq]; // RQ21
          state <= psp_pkg::PSP_PLAY;
          lastApplied <= isLast;
          if (isLast && chainGoes)
          begin
            nextBase <= seqBaseAddress[!applySeq];
            nextTotal <= seqEntryTotal[!applySeq];
            if (applySeq)
              loopsLeft <= loopsLeft - 1'b1; // RQ7
          end
          if (isLast && !chainGoes)
            state <= psp_pkg::PSP_DONE; // RQ1 RQ4
        end
      end
    end
  end

  assign waveRun = genOn;

  // ----------------------------------------------------------------
  // Register reads, one cycle after the strobe
  // ----------------------------------------------------------------
  wire [31:0] statusWord = {20'h0_0000, idx[7:0], cur, genOn, state[1:0]} ^
                           {29'h0000_0000, state[2], 2'b00};
  logic [31:0] readMux;
  always_comb
  begin
    readMux = psp_pkg::ZERO_WORD;
    if (regAddr[7:4] == psp_pkg::OFF_PSEL[7:4])
      readMux = pinSelect[regAddr[3:2]*32 +: 32];
    else if (regAddr[7:4] == psp_pkg::OFF_SEQ0[7:4] || regAddr[7:4] == psp_pkg::OFF_SEQ1[7:4])
    begin
      case (regAddr[3:0])
        psp_pkg::SUB_BASE[3:0]: readMux = 32'(seqBaseAddress[regAddr[4]]);
        psp_pkg::SUB_TOTAL[3:0]: readMux = 32'(seqEntryTotal[regAddr[4]]);
        psp_pkg::SUB_HOLD[3:0]: readMux = 32'(seqHold[regAddr[4]]);
        psp_pkg::SUB_TAIL[3:0]: readMux = 32'(seqTailDelay[regAddr[4]]);
        default: readMux = psp_pkg::ZERO_WORD;
      endcase
    end
    else
    begin
      case (regAddr)
        psp_pkg::OFF_EVENTS: readMux = 32'(evSticky);
        psp_pkg::OFF_ENABLE: readMux = 32'(enable);
        psp_pkg::OFF_DECODE: readMux = 32'(manualStepMode);
        psp_pkg::OFF_CHAIN: readMux = 32'(chainRepeatTotal);
        psp_pkg::OFF_STATUS: readMux = statusWord;
        default: readMux = psp_pkg::ZERO_WORD;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      regRdata <= '0;
    else
      regRdata <= regRd ? readMux : '0;
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_lastOfOne;
    applyNow && isLast && applySeq && chainOn && loopsLeft == LOOP_W'(1);
  endsequence
  property p_loopEnd;
    @(posedge clk) disable iff (sys_rst || dropAll || launchAny)
    s_lastOfOne |=> state == psp_pkg::PSP_DONE && eventPulse[psp_pkg::EV_LOOPS]
      && eventPulse[psp_pkg::EV_FINISH1];
  endproperty
  a_loopEnd: assert property (p_loopEnd) else $error("loop end not reached"); // RQ10
  property p_doneHolds;
    @(posedge clk) disable iff (sys_rst || dropAll)
    state == psp_pkg::PSP_DONE && !launchAny && !haltNow |=> !dutyLoad && $stable(dutyValue);
  endproperty
  a_doneHolds: assert property (p_doneHolds) else $error("value changed after end"); // RQ1
  property p_launchSel;
    @(posedge clk) disable iff (sys_rst || dropAll)
    launchAny |=> cur == $past(launchSel) && state == psp_pkg::PSP_LOAD;
  endproperty
  a_launchSel: assert property (p_launchSel) else $error("wrong first sequence"); // RQ3
  property p_noDoneOnZero;
    @(posedge clk) disable iff (sys_rst || dropAll)
    chainOn && applyNow && isLast && !applySeq |=> state != psp_pkg::PSP_DONE;
  endproperty
  a_noDoneOnZero: assert property (p_noDoneOnZero) else $error("ended on sequence 0"); // RQ4
  property p_range;
    @(posedge clk) disable iff (sys_rst || dropAll)
    dutyLoad |-> idx < actTotal;
  endproperty
  a_range: assert property (p_range) else $error("entry outside sequence"); // RQ5
  property p_hold;
    @(posedge clk) disable iff (sys_rst || dropAll || launchAny || taskStop)
    inPlay && periodDone && !manualStepMode && holdLeft != '0 |=> !dutyLoad;
  endproperty
  a_hold: assert property (p_hold) else $error("load came before hold ended"); // RQ6
  property p_tailOne;
    @(posedge clk) disable iff (sys_rst || dropAll || launchAny)
    state == psp_pkg::PSP_TAIL && tailLeft == '0 && periodDone && fetchValid && !stopPending
      |=> dutyLoad;
  endproperty
  a_tailOne: assert property (p_tailOne) else $error("tail delay overran"); // RQ8
  property p_noFetchRepeat;
    @(posedge clk) disable iff (sys_rst || dropAll)
    applyAny && !fetchValid |=> !dutyLoad && $stable(dutyValue);
  endproperty
  a_noFetchRepeat: assert property (p_noFetchRepeat) else $error("glitch on late fetch"); // RQ13
  property p_halt;
    @(posedge clk) disable iff (sys_rst || dropAll)
    stopPending && genOn && periodDone && !launchAny
      |=> !genOn && eventPulse[psp_pkg::EV_STOPPED] ##1 pinOe == '0;
  endproperty
  a_halt: assert property (p_halt) else $error("halt not done at period end"); // RQ19 RQ17
  property p_step;
    @(posedge clk) disable iff (sys_rst || dropAll)
    manualStepMode && inPlay && !stepPending |=> !dutyLoad;
  endproperty
  a_step: assert property (p_step) else $error("load without step task"); // RQ11

endmodule

/* File: core/psp_pkg.sv */
// Shared constants of the sequence playback block: register map, fields, reset values, states.
// Assumes a single clock domain and a byte-addressed data memory with 16-bit entries.
package psp_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_TASKS = 8'h00;
  localparam logic [7:0] OFF_EVENTS = 8'h04;
  localparam logic [7:0] OFF_ENABLE = 8'h08;
  localparam logic [7:0] OFF_DECODE = 8'h0C;
  localparam logic [7:0] OFF_CHAIN = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_SEQ0 = 8'h20;
  localparam logic [7:0] OFF_SEQ1 = 8'h30;
  localparam logic [7:0] OFF_PSEL = 8'h40;
  localparam logic [7:0] SEQ_STRIDE = 8'h10;
  localparam logic [7:0] SUB_BASE = 8'h00;
  localparam logic [7:0] SUB_TOTAL = 8'h04;
  localparam logic [7:0] SUB_HOLD = 8'h08;
  localparam logic [7:0] SUB_TAIL = 8'h0C;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int TASK_STOP = 0;
  localparam int TASK_LAUNCH0 = 1;
  localparam int TASK_LAUNCH1 = 2;
  localparam int TASK_STEP = 3;
  localparam int EV_STOPPED = 0;
  localparam int EV_BEGUN0 = 1;
  localparam int EV_BEGUN1 = 2;
  localparam int EV_FINISH0 = 3;
  localparam int EV_FINISH1 = 4;
  localparam int EV_PERIOD = 5;
  localparam int EV_LOOPS = 6;
  localparam int EV_COUNT = 7;
  localparam int PSEL_DETACH = 31;
  localparam int PSEL_PIN_W = 5;
  localparam logic [31:0] PSEL_RESET = 32'h8000_0000;
  localparam logic [31:0] ZERO_WORD = 32'h0000_0000;
  localparam int ENTRY_BYTES_LOG2 = 1;

  // ----------------------------------------------------------------
  // Playback states, Gray coded along IDLE-LOAD-PLAY-TAIL-DONE
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PSP_IDLE = 3'b000,
    PSP_LOAD = 3'b001,
    PSP_PLAY = 3'b011,
    PSP_TAIL = 3'b010,
    PSP_DONE = 3'b110
  } psp_state_e;

endpackage

/* File: core/psp_fetch.sv */
// Duty entry fetcher: one outstanding read toward data memory, result held until consumed.
// Assumes memory answers a read with a one-cycle memRdAck, any number of cycles later.
`timescale 1ns/1ps
module psp_fetch #(
  parameter int ADDR_W = 32
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic fetchGo,
  input wire logic [ADDR_W-1:0] fetchAddr,
  input wire logic fetchTake,
  output logic fetchValid,
  output logic [15:0] fetchData,
  output logic memRdReq,
  output logic [ADDR_W-1:0] memAddr,
  input wire logic memRdAck,
  input wire logic [15:0] memRdData
);

  logic waiting;

  // A new request drops any unused result so a stale entry is never applied.
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      waiting <= 1'b0;
      memRdReq <= 1'b0;
      memAddr <= '0;
      fetchValid <= 1'b0;
      fetchData <= '0;
    end
    else
    begin
      memRdReq <= fetchGo;
      if (fetchGo)
      begin
        memAddr <= fetchAddr;
        waiting <= 1'b1;
        fetchValid <= 1'b0;
      end
      else if (waiting && memRdAck)
      begin
        waiting <= 1'b0;
        fetchValid <= 1'b1;
        fetchData <= memRdData;
      end
      else if (fetchTake)
      begin
        fetchValid <= 1'b0;
      end
    end
  end

endmodule

/* File: core/psp_pinmap.sv */
// Routes the four channel waves to physical pins and releases pins to GPIO when idle.
// Assumes GPIO drives its own idle level on any pin whose enable here is low.
`timescale 1ns/1ps
module psp_pinmap #(
  parameter int NUM_PINS = 32,
  parameter int NUM_CH = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic driveOn,
  input wire logic [NUM_CH-1:0] chanWave,
  input wire logic [NUM_CH*32-1:0] pinSelect,
  output logic [NUM_PINS-1:0] pinOut,
  output logic [NUM_PINS-1:0] pinOe
);

  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++)
    begin : g_pin
      logic hit;
      logic lvl;
      always_comb
      begin
        hit = 1'b0;
        lvl = 1'b0;
        for (int c = 0; c < NUM_CH; c++)
        begin
          if (!pinSelect[c*32+psp_pkg::PSEL_DETACH] &&
              pinSelect[c*32 +: psp_pkg::PSEL_PIN_W] == psp_pkg::PSEL_PIN_W'(p))
          begin
            hit = 1'b1;
            lvl = chanWave[c];
          end
        end
      end
      // Detached channels never match, so they drive nothing. RQ14
      always_ff @(posedge clk)
      begin
        if (sys_rst)
        begin
          pinOe[p] <= 1'b0;
          pinOut[p] <= 1'b0;
        end
        else
        begin
          pinOe[p] <= driveOn && hit; // RQ17
          pinOut[p] <= lvl;
        end
      end
    end
  endgenerate

endmodule

/* File: bench/psp_mem_model.sv */
// Data memory model answering duty-entry reads with an address-derived pattern.
// Assumes one read outstanding; a newer request restarts the wait.
`timescale 1ns/1ps
module psp_mem_model (
  input wire logic clk,
  input wire logic [7:0] lat,
  input wire logic memRdReq,
  input wire logic [31:0] memAddr,
  output logic memRdAck,
  output logic [15:0] memRdData
);
  logic [7:0] waitCnt;
  logic busy;
  initial
  begin
    busy = 1'h0;
    waitCnt = 8'h00;
    memRdAck = 1'h0;
    memRdData = 16'h0000;
  end
  // Data toggles outside the ack cycle so a late sample cannot pass by luck.
  always @(posedge clk)
  begin
    memRdAck <= 1'h0;
    memRdData <= ~memRdData;
    if (memRdReq)
    begin
      busy <= 1'h1;
      waitCnt <= lat;
    end
    else if (busy && waitCnt == 8'h00)
    begin
      busy <= 1'h0;
      memRdAck <= 1'h1;
      memRdData <= memAddr[15:0] ^ 16'h5a3c;
    end
    else if (busy)
      waitCnt <= waitCnt - 8'h01;
  end
endmodule

/* File: bench/psp_playback_bench.sv */
// Self-checking bench: chained, single-shot, manual-step, halt and power-off cases.
// Assumes the memory model beside it; the wave counter is emulated here.
`timescale 1ns/1ps
module psp_playback_bench;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [7:0] regAddr = 8'h00;
  logic [31:0] regWdata = 32'h0000_0000;
  logic regWr = 1'h0;
  logic regRd = 1'h0;
  logic periodDone = 1'h0;
  logic [3:0] chanWave = 4'h0;
  logic powerOff = 1'h0;
  logic [7:0] lat = 8'h02;
  logic rdPend = 1'h0;
  logic [2:0] phase = 3'h0;
  logic runD = 1'h0;
  logic [31:0] regRdata, memAddr, pinOut, pinOe;
  logic [15:0] dutyValue, memRdData;
  logic [psp_pkg::EV_COUNT-1:0] eventPulse;
  logic waveRun, dutyLoad, memRdReq, memRdAck;
  int err_count = 0, comparisons = 0, cycles = 0, loads = 0, lastLoad = 0;
  int gaps[3] = '{16, 24, 8};
  int ev[psp_pkg::EV_COUNT] = '{default: 0};
  int seed = 32'h26b2;
  logic [31:0] rdq[$];
  logic [15:0] dq[$];
  psp_playback i_psp_playback (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .periodDone(periodDone), .chanWave(chanWave), .waveRun(waveRun),
    .dutyValue(dutyValue), .dutyLoad(dutyLoad), .memRdReq(memRdReq), .memAddr(memAddr),
    .memRdAck(memRdAck), .memRdData(memRdData), .powerOff(powerOff),
    .eventPulse(eventPulse), .pinOut(pinOut), .pinOe(pinOe));
  psp_mem_model i_psp_mem_model (.clk(clk), .lat(lat), .memRdReq(memRdReq),
    .memAddr(memAddr), .memRdAck(memRdAck), .memRdData(memRdData));
  always #25 clk = ~clk;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude;
    $display("errors %0d comparisons %0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'h1;
    @(posedge clk);
    regWr <= 1'h0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] e);
    rdq.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'h1;
    @(posedge clk);
    regRd <= 1'h0;
  endtask
  task seq(input logic [7:0] o, input logic [31:0] b, t, h, d);
    wr(o + psp_pkg::SUB_BASE, b);
    wr(o + psp_pkg::SUB_TOTAL, t);
    wr(o + psp_pkg::SUB_HOLD, h);
    wr(o + psp_pkg::SUB_TAIL, d);
  endtask
  task automatic exp(input logic [31:0] b, input int n);
    for (int i = 0; i < n; i++)
      dq.push_back(b[15:0] + 16'(2 * i) ^ 16'h5a3c);
  endtask
  // ----------------------------------------------------------------
  // Wave counter emulation and output watcher
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    cycles++;
    phase <= phase + 3'h1;
    periodDone <= (phase == 3'h6);
    if (phase == 3'h6)
      chanWave <= 4'($random(seed));
    rdPend <= regRd;
    runD <= waveRun && !powerOff;
    if (rdPend)
      chk(regRdata, rdq.pop_front());
    if (dutyLoad === 1'h1)
    begin
      loads++;
      chk({16'h0000, dutyValue}, {16'h0000, dq.pop_front()});
      // Hold 1 doubles the spacing, tail 1 adds one period, hold 0 gives a single period.
      if (loads >= 3 && loads <= 5)
        chk(cycles - lastLoad, gaps[loads-3]);
      lastLoad = cycles;
    end
    // Pins follow generation one cycle late, so the delayed run flag gates this.
    if (runD === 1'h1 && phase == 3'h3)
      chk({pinOe[5], pinOut[5]}, {1'h1, chanWave[0]});
    for (int i = 0; i < psp_pkg::EV_COUNT; i++)
      if (eventPulse[i] === 1'h1)
        ev[i]++;
    if (cycles > 20000)
    begin
      err_count++;
      conclude;
    end
  end
  initial
  begin
    repeat (3) @(posedge clk);
    sys_rst <= 1'h0;
    rd(psp_pkg::OFF_PSEL, psp_pkg::PSEL_RESET);
    rd(8'hfc, 32'h0000_0000);
    wr(psp_pkg::OFF_PSEL, 32'h0000_0005);
    wr(psp_pkg::OFF_ENABLE, 32'h0000_0001);
    seq(psp_pkg::OFF_SEQ0, 32'h0000_0100, 32'h0000_0003, 32'h0000_0001, 32'h0000_0001);
    seq(psp_pkg::OFF_SEQ1, 32'h0000_0200, 32'h0000_0002, 32'h0000_0000, 32'h0000_0000);
    wr(psp_pkg::OFF_CHAIN, 32'h0000_0001);
    exp(32'h0000_0100, 3);
    exp(32'h0000_0200, 2);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0002);
    while (ev[psp_pkg::EV_LOOPS] < 1) @(posedge clk);
    repeat (80) @(posedge clk);
    chk(ev[psp_pkg::EV_FINISH1], 1);
    chk(ev[psp_pkg::EV_FINISH0], 1);
    chk(loads, 5);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0001);
    while (ev[psp_pkg::EV_STOPPED] < 1) @(posedge clk);
    repeat (2) @(posedge clk);
    chk({31'h0000_0000, waveRun}, 32'h0000_0000);
    chk(pinOe, 32'h0000_0000);
    lat <= 8'h0c;
    wr(psp_pkg::OFF_CHAIN, 32'h0000_0000);
    exp(32'h0000_0200, 2);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0004);
    while (ev[psp_pkg::EV_FINISH1] < 2) @(posedge clk);
    chk(ev[psp_pkg::EV_BEGUN1], 2);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0001);
    while (ev[psp_pkg::EV_STOPPED] < 2) @(posedge clk);
    lat <= 8'h02;
    wr(psp_pkg::OFF_DECODE, 32'h0000_0001);
    exp(32'h0000_0100, 1);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0002);
    repeat (60) @(posedge clk);
    chk(loads, 8);
    exp(32'h0000_0102, 1);
    wr(psp_pkg::OFF_TASKS, 32'h0000_0008);
    repeat (30) @(posedge clk);
    chk(loads, 9);
    powerOff <= 1'h1;
    repeat (3) @(posedge clk);
    chk({31'h0000_0000, waveRun}, 32'h0000_0000);
    chk(pinOe, 32'h0000_0000);
    powerOff <= 1'h0;
    rd(psp_pkg::OFF_PSEL, psp_pkg::PSEL_RESET);
    repeat (2) @(posedge clk);
    chk(dq.size(), 0);
    conclude;
  end
endmodule
